// ==== inc/tsp_pkg.sv ====
/*
  package for the totalize stamp processor: register map, field layout,
  capture carrier types and time scaling constants.
  assumes nothing beyond a SystemVerilog compiler.
*/
package tsp_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int EVT_W   = 32;
  localparam int TIME_W  = 32;
  localparam int INT_W   = 16;
  localparam int STAMP_W = 48;  // corrected counts (count + correction)
  localparam int TS_W    = 56;  // time stamps in units of 0.1 ns

  // ----------------------------------------------------------------
  // interpolator/status field bit positions
  // ----------------------------------------------------------------
  localparam int BIT_BLOCK_START  = 0;
  localparam int BIT_INHIBIT      = 1;
  localparam int BIT_FIRST_FLAG   = 13;  // sampled arming layout
  localparam int BIT_SECOND_FLAG  = 14;  // time/interval arming layout
  localparam logic [INT_W-1:0] INT_VALUE_MASK = 16'h1fff;

  // ----------------------------------------------------------------
  // time scaling: stamp in 0.1 ns units
  // ----------------------------------------------------------------
  localparam int TIME_TICK_PS  = 2000;  // 2 ns per time count
  localparam int INTERP_TICK_PS = 100;  // 0.1 ns per interpolator count
  localparam logic [7:0] TIME_SCALE = 8'(TIME_TICK_PS / INTERP_TICK_PS);

  // ----------------------------------------------------------------
  // apb register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_EVT_CORR  = 8'h04;
  localparam logic [7:0] OFS_TIME_CORR = 8'h08;
  localparam logic [7:0] OFS_STATUS    = 8'h0c;
  localparam logic [7:0] OFS_SAMPLES   = 8'h10;
  localparam int CTRL_LAYOUT_BIT = 0;  // 0: bit-13 layout, 1: bit-14 layout
  localparam int CTRL_GATE_BIT   = 1;  // produce gate times
  localparam int CTRL_CLEAR_BIT  = 2;  // write 1: restart the block
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
  localparam logic [31:0] EVT_CORR_RESET  = 32'h0000_0000;
  localparam logic [31:0] TIME_CORR_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [EVT_W-1:0]  evt;
    logic [TIME_W-1:0] tim;
    logic [INT_W-1:0]  intp;
  } capture_s;

  typedef struct packed {
    logic [STAMP_W-1:0] total;
    logic [TS_W-1:0]    gate;
    logic               gate_vld;
    logic               block_start;
    logic               inhibit;
  } result_s;

  typedef enum logic [1:0] {
    ST_FIRST  = 2'b00,
    ST_SECOND = 2'b01
  } phase_e;

endpackage : tsp_pkg

// ==== rtl/tsp_rollover.sv ====
/*
  rollover corrector: adds an accumulated correction to a count stream
  and grows the correction whenever a count falls below its predecessor.
  assumes in_vld pulses once per sample and corr is stable during a block.
*/
module tsp_rollover (
  // clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        ce,
  input  wire logic                        clr,
  // stream
  input  wire logic                        in_vld,
  input  wire logic [31:0]                 in_cnt,
  input  wire logic [31:0]                 corr,
  output logic      [tsp_pkg::STAMP_W-1:0] out_cnt
);
  logic [31:0]                 prev_q;
  logic                        have_q;
  logic [tsp_pkg::STAMP_W-1:0] acc_q;
  logic [tsp_pkg::STAMP_W-1:0] acc_d;

  // a smaller count than before means the hardware counter wrapped
  always_comb begin
    acc_d = acc_q;
    if (have_q && (in_cnt < prev_q)) begin
      acc_d = acc_q + tsp_pkg::STAMP_W'(corr);
    end
  end

  assign out_cnt = tsp_pkg::STAMP_W'(in_cnt) + acc_d;

  // correction persists for all later samples of the block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 32'h0000_0000;
      have_q <= 1'b0;
      acc_q  <= '0;
    end else if (ce) begin
      if (clr) begin
        have_q <= 1'b0;
        acc_q  <= '0;
      end else if (in_vld) begin
        prev_q <= in_cnt;
        have_q <= 1'b1;
        acc_q  <= acc_d;
      end
    end
  end

  // a wrapped count must grow the correction by exactly one step
  AST_ROLL_ACC: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && !clr && in_vld && have_q && (in_cnt < prev_q))
      |=> acc_q == $past(acc_q) + tsp_pkg::STAMP_W'($past(corr)))
    else $error("wrapped count did not grow the correction");
endmodule : tsp_rollover

// ==== rtl/tsp_stamp.sv ====
/*
  time stamp former: stamp = count * 20 - interpolator, in 0.1 ns units.
  assumes a combinational path is acceptable at 125 MHz for one multiply.
*/
module tsp_stamp (
  // inputs
  input  wire logic [tsp_pkg::STAMP_W-1:0] cnt,
  input  wire logic [tsp_pkg::INT_W-1:0]   intp,
  // stamp
  output logic      [tsp_pkg::TS_W-1:0]    stamp
);
  // interpolator weight is one tenth of a nanosecond
  assign stamp = tsp_pkg::TS_W'(cnt) * tsp_pkg::TS_W'(tsp_pkg::TIME_SCALE)
               - tsp_pkg::TS_W'(intp & tsp_pkg::INT_VALUE_MASK);
endmodule : tsp_stamp

// ==== rtl/tsp_core.sv ====
/*
  totalize stamp processor: merges capture pairs into valid samples,
  corrects rollovers, forms time stamps and emits totalize counts and
  optional gate times, with an apb slave for configuration and status.
  assumes captures come from logic on pclk, one per cap_vld pulse,
  first and second capture alternating.
*/
// The address map and the APB register port were decided locally.
module tsp_core (
  // clock, reset, enable
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    ce,
  // apb slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // capture stream
  input  wire logic                    cap_vld,
  input  wire tsp_pkg::capture_s       cap,
  // results
  output logic                         res_vld,
  output tsp_pkg::result_s             res
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0]                 ctrl_q;
  logic [31:0]                 evt_corr_q;
  logic [31:0]                 time_corr_q;
  logic [31:0]                 samples_q;
  logic                        clr_q;
  logic                        apb_acc;
  logic                        apb_wr;
  logic [31:0]                 rd_d;
  logic                        unmapped;
  tsp_pkg::phase_e             phase_q;      // pairing state, read back in status
  logic                        have_prev_q;  // a sample is held for differencing

  // the pready cycle is excluded so that each transfer is taken exactly once
  assign apb_acc = psel && penable && !pready;
  assign apb_wr  = apb_acc && pwrite;

  // read mux; unmapped addresses answer with pslverr
  always_comb begin
    rd_d     = 32'h0000_0000;
    unmapped = 1'b0;
    case (paddr)
      tsp_pkg::OFS_CTRL:      rd_d = ctrl_q;
      tsp_pkg::OFS_EVT_CORR:  rd_d = evt_corr_q;
      tsp_pkg::OFS_TIME_CORR: rd_d = time_corr_q;
      tsp_pkg::OFS_STATUS:    rd_d = {30'h0, phase_q == tsp_pkg::ST_SECOND, have_prev_q};
      tsp_pkg::OFS_SAMPLES:   rd_d = samples_q;
      default:                unmapped = 1'b1;
    endcase
  end

  // one wait state: pready answers in the first access cycle's next edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      pready  <= apb_acc;
      pslverr <= apb_acc && unmapped;
      if (apb_acc && !pwrite) begin
        prdata <= rd_d;
      end
    end
  end

  // configuration writes; clear bit self-clears to a one-cycle pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q      <= tsp_pkg::CTRL_RESET;
      evt_corr_q  <= tsp_pkg::EVT_CORR_RESET;
      time_corr_q <= tsp_pkg::TIME_CORR_RESET;
      clr_q       <= 1'b0;
    end else if (ce) begin
      clr_q <= 1'b0;
      if (apb_wr) begin
        case (paddr)
          tsp_pkg::OFS_CTRL: begin
            ctrl_q <= pwdata & 32'h0000_0003;
            clr_q  <= pwdata[tsp_pkg::CTRL_CLEAR_BIT];
          end
          tsp_pkg::OFS_EVT_CORR:  evt_corr_q  <= pwdata;
          tsp_pkg::OFS_TIME_CORR: time_corr_q <= pwdata;
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // capture pairing
  // ----------------------------------------------------------------
  logic [31:0]                 first_evt_q;
  logic                        first_bs_q;
  logic                        first_inh_q;
  logic                        sel_flag;
  logic [31:0]                 valid_evt;
  logic                        sample_vld;

  // captures alternate first, second within each sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q     <= tsp_pkg::ST_FIRST;
      first_evt_q <= 32'h0000_0000;
      first_bs_q  <= 1'b0;
      first_inh_q <= 1'b0;
    end else if (ce) begin
      if (clr_q) begin
        phase_q <= tsp_pkg::ST_FIRST;
      end else if (cap_vld) begin
        case (phase_q)
          tsp_pkg::ST_FIRST: begin
            phase_q     <= tsp_pkg::ST_SECOND;
            first_evt_q <= cap.evt;
            first_bs_q  <= cap.intp[tsp_pkg::BIT_BLOCK_START];
            first_inh_q <= cap.intp[tsp_pkg::BIT_INHIBIT];
          end
          tsp_pkg::ST_SECOND: phase_q <= tsp_pkg::ST_FIRST;
          default:            phase_q <= tsp_pkg::ST_FIRST;
        endcase
      end
    end
  end

  assign sample_vld = ce && !clr_q && cap_vld && (phase_q == tsp_pkg::ST_SECOND);

  // layout bit picks which status bit selects the valid count
  assign sel_flag = ctrl_q[tsp_pkg::CTRL_LAYOUT_BIT]
                  ? cap.intp[tsp_pkg::BIT_SECOND_FLAG]
                  : cap.intp[tsp_pkg::BIT_FIRST_FLAG];

  // second capture minus one when the first attempt missed
  assign valid_evt = sel_flag ? (cap.evt - 32'h0000_0001)
                              : first_evt_q;

  // ----------------------------------------------------------------
  // rollover correction and stamps
  // ----------------------------------------------------------------
  logic [tsp_pkg::STAMP_W-1:0] evt_stamp;
  logic [tsp_pkg::STAMP_W-1:0] time_cnt;
  logic [tsp_pkg::TS_W-1:0]    time_stamp;

  tsp_rollover u_evt_roll (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .clr     (clr_q),
    .in_vld  (sample_vld),
    .in_cnt  (valid_evt),
    .corr    (evt_corr_q),
    .out_cnt (evt_stamp)
  );

  tsp_rollover u_time_roll (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .clr     (clr_q),
    .in_vld  (sample_vld),
    .in_cnt  (cap.tim),
    .corr    (time_corr_q),
    .out_cnt (time_cnt)
  );

  tsp_stamp u_stamp (
    .cnt   (time_cnt),
    .intp  (cap.intp),
    .stamp (time_stamp)
  );

  // ----------------------------------------------------------------
  // differences between consecutive samples
  // ----------------------------------------------------------------
  logic [tsp_pkg::STAMP_W-1:0] prev_evt_q;
  logic [tsp_pkg::TS_W-1:0]    prev_ts_q;
  logic                        prev_bs_q;
  logic                        prev_inh_q;

  // the first sample of a block only primes the history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_evt_q  <= '0;
      prev_ts_q   <= '0;
      prev_bs_q   <= 1'b0;
      prev_inh_q  <= 1'b0;
      have_prev_q <= 1'b0;
      samples_q   <= 32'h0000_0000;
    end else if (ce) begin
      if (clr_q) begin
        have_prev_q <= 1'b0;
        samples_q   <= 32'h0000_0000;
      end else if (sample_vld) begin
        prev_evt_q  <= evt_stamp;
        prev_ts_q   <= time_stamp;
        prev_bs_q   <= first_bs_q;
        prev_inh_q  <= first_inh_q;
        have_prev_q <= 1'b1;
        samples_q   <= samples_q + 32'h0000_0001;
      end
    end
  end

  // results describe the interval that starts at the previous sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_vld <= 1'b0;
      res     <= '0;
    end else if (ce) begin
      res_vld <= sample_vld && have_prev_q;
      if (sample_vld && have_prev_q) begin
        res.total       <= evt_stamp - prev_evt_q;
        res.gate_vld    <= ctrl_q[tsp_pkg::CTRL_GATE_BIT];
        res.gate        <= ctrl_q[tsp_pkg::CTRL_GATE_BIT]
                         ? (time_stamp - prev_ts_q) : '0;
        res.block_start <= prev_bs_q;
        res.inhibit     <= prev_inh_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_PAIR_ALTERNATES: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && cap_vld && !clr_q && phase_q == tsp_pkg::ST_FIRST) |=> phase_q == tsp_pkg::ST_SECOND)
    else $error("first capture did not advance to second");

  AST_FLAG_ZERO_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
    (sample_vld && !sel_flag) |-> valid_evt == first_evt_q)
    else $error("flag zero must pick first capture");

  AST_FLAG_ONE_SECOND: assert property (@(posedge pclk) disable iff (!presetn)
    (sample_vld && sel_flag) |-> valid_evt == cap.evt - 32'h0000_0001)
    else $error("flag one must pick second capture minus one");

  AST_LAYOUT13: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_q[tsp_pkg::CTRL_LAYOUT_BIT] |-> sel_flag == cap.intp[13])
    else $error("sampled layout must use bit 13");

  AST_LAYOUT14: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_q[tsp_pkg::CTRL_LAYOUT_BIT] |-> sel_flag == cap.intp[14])
    else $error("time/interval layout must use bit 14");

  AST_TOTAL_DIFF: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && sample_vld && have_prev_q) |=> res_vld && res.total == $past(evt_stamp) - $past(prev_evt_q))
    else $error("totalize result is not the stamp difference");

  AST_GATE_DIFF: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && sample_vld && have_prev_q && ctrl_q[1]) |=> res.gate == $past(time_stamp) - $past(prev_ts_q))
    else $error("gate time is not the stamp difference");

  AST_GATE_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    (res_vld && !res.gate_vld) |-> res.gate == '0)
    else $error("gate time produced while disabled");

  AST_NO_FIRST_RESULT: assert property (@(posedge pclk) disable iff (!presetn)
    (sample_vld && !have_prev_q) |=> !res_vld)
    else $error("result emitted without a previous sample");

  AST_FIRST_CAP_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && cap_vld && !clr_q && phase_q == tsp_pkg::ST_FIRST) |=> !res_vld)
    else $error("first capture alone produced a result");

  AST_SECOND_RETURNS: assert property (@(posedge pclk) disable iff (!presetn)
    sample_vld |=> phase_q == tsp_pkg::ST_FIRST)
    else $error("second capture did not close the sample");

  AST_RESULT_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && res_vld) |=> !res_vld)
    else $error("result valid stood for more than one cycle");

  AST_STATUS_CARRY: assert property (@(posedge pclk) disable iff (!presetn)
    (sample_vld && have_prev_q)
      |=> res.block_start == $past(prev_bs_q) && res.inhibit == $past(prev_inh_q))
    else $error("block start or inhibit not carried into the result");

  // a low enable must leave pairing, history and results untouched
  AST_CE_FREEZE: assert property (@(posedge pclk) disable iff (!presetn)
    !ce |=> $stable(phase_q) && $stable(res_vld) && $stable(samples_q))
    else $error("state changed while the clock enable was low");
endmodule : tsp_core

// ==== sim/tsp_capture_src.sv ====
/*
  capture stream source: plays one sample as a first and a second capture.
  assumes the bench pulses send for one pclk cycle while busy is low.
*/
module tsp_capture_src (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // command from the bench
  input  wire logic              send,
  input  wire logic [3:0]        gap,
  input  wire tsp_pkg::capture_s c1,
  input  wire tsp_pkg::capture_s c2,
  output logic                   busy,
  // capture stream
  output logic                   cap_vld,
  output tsp_pkg::capture_s      cap
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [3:0]        wait_q;
  logic              pend_q;
  tsp_pkg::capture_s c2_q;

  assign busy = pend_q;

  // first capture on send, second after gap idle cycles (0 = back to back)
  // idle bus shows the inverse of its last value so stale data never matches
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q  <= 1'b0;
      wait_q  <= 4'h0;
      cap_vld <= 1'b0;
      cap     <= '0;
    end else if (send && !pend_q) begin
      cap_vld <= 1'b1;
      cap     <= c1;
      c2_q    <= c2;
      wait_q  <= gap;
      pend_q  <= 1'b1;
    end else if (pend_q && wait_q == 4'h0) begin
      cap_vld <= 1'b1;
      cap     <= c2_q;
      pend_q  <= 1'b0;
    end else begin
      cap_vld <= 1'b0;
      cap     <= ~cap;
      if (pend_q) begin
        wait_q <= wait_q - 4'h1;
      end
    end
  end
endmodule : tsp_capture_src

// ==== sim/test_totalize_stamp_processor.sv ====
/*
  testbench for the totalize stamp processor: apb set-up, sample table
  played in both flag layouts, with and without gate times, then resets.
  assumes tsp_pkg, tsp_core and the capture source model are compiled first.
*/
module test_totalize_stamp_processor;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic [31:0] e1;
    logic [31:0] e2;
    logic [31:0] tim;
    logic [12:0] iv;
    logic        f;
    logic [1:0]  bsi;  // bit1 inhibit, bit0 block start
    logic [3:0]  gap;
    logic [31:0] v;    // expected valid event count
  } row_s;

  localparam logic [31:0] EC = 32'h1000_0000;
  localparam logic [31:0] TC = 32'h0000_8000;

  logic              pclk    = 1'b0;
  logic              presetn = 1'b0;
  logic              ce      = 1'b1;
  logic              psel    = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite  = 1'b0;
  logic [7:0]        paddr   = 8'h00;
  logic [31:0]       pwdata  = 32'h0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              cap_vld;
  tsp_pkg::capture_s cap;
  logic              res_vld;
  tsp_pkg::result_s  res;
  logic              send    = 1'b0;
  logic [3:0]        gap     = 4'h0;
  tsp_pkg::capture_s c1      = '0;
  tsp_pkg::capture_s c2      = '0;
  logic              busy;
  int                error_cnt = 0;
  int                checks    = 0;
  logic [31:0]       rd;
  logic              er;
  logic [31:0]       pv;
  logic [31:0]       pt;
  logic [47:0]       pe;
  logic [47:0]       acc_e;
  logic [47:0]       acc_t;
  logic [47:0]       ev;
  logic [55:0]       pts;
  logic [55:0]       ts;
  logic [1:0]        pbsi;
  logic              have;
  logic              lay;
  logic              gen;

  // ordinary cases: flag 0/1, wrap of evt-1, event and time rollover
  row_s rows [6] = '{
    '{32'h64, 32'h3e7, 32'h3e8, 13'h0005, 1'b0, 2'h1, 4'h0, 32'h64},
    '{32'h5, 32'hfb, 32'h7d0, 13'h1fff, 1'b1, 2'h2, 4'h3, 32'hfa},
    '{32'hffff_fff0, 32'h0, 32'hbb8, 13'h0007, 1'b0, 2'h0, 4'h0, 32'hffff_fff0},
    '{32'h1, 32'h0, 32'hffff_fff0, 13'h0000, 1'b1, 2'h0, 4'h2, 32'hffff_ffff},
    '{32'ha, 32'h0, 32'h14, 13'h0003, 1'b0, 2'h3, 4'h1, 32'ha},
    '{32'h0, 32'h1f, 32'h28, 13'h0000, 1'b1, 2'h1, 4'h0, 32'h1e}
  };

  always #4 pclk = ~pclk;

  tsp_core DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cap_vld(cap_vld), .cap(cap), .res_vld(res_vld), .res(res));

  tsp_capture_src src (.pclk(pclk), .presetn(presetn), .send(send), .gap(gap), .c1(c1),
    .c2(c2), .busy(busy), .cap_vld(cap_vld), .cap(cap));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      error_cnt++;
      end_sim();
    end
  endtask : apb

  // first capture carries junk time and junk status bits above bit 1
  task automatic put(input row_s r);
    tsp_pkg::capture_s a;
    tsp_pkg::capture_s b;
    int                n;
    a.evt  = r.e1;
    a.tim  = ~r.tim;
    a.intp = {14'h3fff, r.bsi};
    b.evt  = r.e2;
    b.tim  = r.tim;
    b.intp = {1'b1, lay ? r.f : ~r.f, lay ? ~r.f : r.f, r.iv};
    c1   <= a;
    c2   <= b;
    gap  <= r.gap;
    send <= 1'b1;
    @(posedge pclk);
    send <= 1'b0;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while ((busy || n < 2) && n < 30);
    if (n >= 30) begin
      error_cnt++;
      end_sim();
    end
    if (have) begin
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (res_vld !== 1'b1 && n < 30);
      if (n >= 30) begin
        error_cnt++;
        end_sim();
      end
    end
  endtask : put

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge pclk);
    chk(64'(res_vld), 64'h0);
    chk(64'(res.total), 64'h0);
    presetn <= 1'b1;
    // pass 0: bit-13 layout, pass 1: bit-14 layout, pass 2: gate times off
    for (int p = 0; p < 3; p++) begin
      lay = (p == 1);
      gen = (p != 2);
      apb(1'b1, tsp_pkg::OFS_EVT_CORR, EC);
      apb(1'b1, tsp_pkg::OFS_TIME_CORR, TC);
      apb(1'b1, tsp_pkg::OFS_CTRL, {29'h0, 1'b1, gen, lay});
      apb(1'b0, tsp_pkg::OFS_CTRL, 32'h0);
      chk(64'(rd), {62'h0, gen, lay});
      apb(1'b0, tsp_pkg::OFS_TIME_CORR, 32'h0);
      chk(64'(rd), 64'(TC));
      have  = 1'b0;
      acc_e = '0;
      acc_t = '0;
      foreach (rows[i]) begin
        if (have && rows[i].v < pv) acc_e += 48'(EC);
        if (have && rows[i].tim < pt) acc_t += 48'(TC);
        ev = 48'(rows[i].v) + acc_e;
        ts = 56'(48'(rows[i].tim) + acc_t) * 56'd20 - 56'(rows[i].iv);
        put(rows[i]);
        if (have) begin
          chk(64'(res.total), 64'(48'(ev - pe)));
          chk(64'(res.gate_vld), 64'(gen));
          if (gen) chk(64'(res.gate), 64'(56'(ts - pts)));
          else chk(64'(res.gate), 64'h0);
          chk(64'({res.inhibit, res.block_start}), 64'(pbsi));
        end
        have = 1'b1;
        pv   = rows[i].v;
        pt   = rows[i].tim;
        pe   = ev;
        pts  = ts;
        pbsi = rows[i].bsi;
      end
      apb(1'b0, tsp_pkg::OFS_SAMPLES, 32'h0);
      chk(64'(rd), 64'h6);
    end
    // clock enable low freezes the block: a whole sample is ignored
    ce   <= 1'b0;
    send <= 1'b1;
    @(posedge pclk);
    send <= 1'b0;
    repeat (6) begin
      @(posedge pclk);
      chk(64'(res_vld), 64'h0);
    end
    ce <= 1'b1;
    apb(1'b0, tsp_pkg::OFS_SAMPLES, 32'h0);
    chk(64'(rd), 64'h6);
    apb(1'b0, tsp_pkg::OFS_STATUS, 32'h0);
    chk(64'(rd), 64'h1);
    // unmapped address is refused with error and zero data
    apb(1'b0, 8'h14, 32'h0);
    chk(64'({er, rd}), {31'h0, 1'b1, 32'h0});
    // second reset in mid-run brings registers back to zero
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    chk(64'(res_vld), 64'h0);
    chk(64'(res.total), 64'h0);
    presetn <= 1'b1;
    apb(1'b0, tsp_pkg::OFS_CTRL, 32'h0);
    chk(64'(rd), 64'(tsp_pkg::CTRL_RESET));
    apb(1'b0, tsp_pkg::OFS_EVT_CORR, 32'h0);
    chk(64'(rd), 64'(tsp_pkg::EVT_CORR_RESET));
    end_sim();
  end
endmodule : test_totalize_stamp_processor
